// >>> core/indirect_access_defines.svh
`ifndef INDIRECT_ACCESS_DEFINES_SVH
`define INDIRECT_ACCESS_DEFINES_SVH
// ==========================================
// Direct register addresses (two host address lines)
`define DIR_MASTER 2'h0
`define DIR_SLOT_INDEX 2'h1
`define DIR_SELECTOR 2'h2
`define DIR_DATA 2'h3
// ==========================================
// Master control bit positions
`define MCR_BUSY_BIT 0
`define MCR_SOFT_RESET_BIT 7
// ==========================================
// Selector fields
`define SEL_SPACE_MSB 7
`define SEL_SPACE_LSB 4
`define SEL_LOW_MSB 3
`define SEL_LOW_LSB 0
// ==========================================
// Control register offsets
`define CR_MAIN_CLOCK_SELECT 8'h00
`define CR_NETWORK_REFERENCE_CLOCK_CLOCK_SELECT 8'h01
`define CR_PROG_CLOCK_OUTPUTS 8'h02
`define CR_CLOCK_RESOURCE_SELECT 8'h03
`define CR_FALLBACK_CLOCK_SELECT 8'h04
`define CR_LOCAL_CLOCKS_UPPER 8'h05
`define CR_LOCAL_CLOCKS_LOWER 8'h06
`define CR_MAIN_CLOCK_DIVIDER 8'h07
`define CR_NETWORK_REFERENCE_CLOCK_CLOCK_DIVIDER 8'h08
`define CR_RESOURCE_CLOCK_DIVIDER 8'h09
`define CR_LOCAL_STREAM_CONTROL 8'h0C
`define CR_CONNECTION_DELAY_TYPE 8'h0E
`define CR_BACKPLANE_LOW 8'h10
`define CR_BACKPLANE_HIGH 8'h11
`define CR_GENERAL_PURPOSE_IO 8'h18
`define CR_FRAME_A_START_LOW 8'h20
`define CR_FRAME_A_HIGH 8'h21
`define CR_FRAME_B_START_LOW 8'h22
`define CR_FRAME_B_HIGH 8'h23
`define CR_FRAME_B_OUT_LOW 8'h24
`define CR_FRAME_B_OUT_HIGH 8'h25
`define CR_CLOCK_ERROR_IND 8'h28
`define CR_CLOCK_ERROR_STAT 8'h29
`define CR_SYSTEM_ERROR_FLAGS 8'h2A
`define CR_CLOCK_WATCHDOG_MASK 8'h2B
`define CR_DIAG_ONE 8'h30
`define CR_DIAG_TWO 8'h31
`define CR_DIAG_THREE 8'h32
`define CR_RESET_VALUE 8'h00
// ==========================================
// Search memory run phase length in clock cycles; the done cycle adds one more
`define SEARCH_OP_CYCLES 4'h4
`endif

// >>> core/indirect_access_pkg.sv
`default_nettype none
package indirect_access_pkg;
   // ==========================================
   // Decoded target of the selector byte
   typedef enum logic [4:0] {
      TGT_CONTROL = 5'h00,
      TGT_LOCAL_DATA_ONE = 5'h01,
      TGT_LOCAL_DATA_TWO = 5'h02,
      TGT_LOCAL_CONN_SLOT = 5'h03,
      TGT_LOCAL_CONN_STREAM = 5'h04,
      TGT_LOCAL_HOLD_WIPE = 5'h05,
      TGT_SEARCH_DATA_ONE = 5'h06,
      TGT_SEARCH_DATA_TWO = 5'h07,
      TGT_SEARCH_SLOT = 5'h08,
      TGT_SEARCH_STREAM = 5'h09,
      TGT_SEARCH_TAG = 5'h0A,
      TGT_MAKE_LINK = 5'h0B,
      TGT_BREAK_LINK = 5'h0C,
      TGT_CLEAR_SLOT = 5'h0D,
      TGT_READ_SLOT = 5'h0E,
      TGT_SEARCH = 5'h0F,
      TGT_WIPE = 5'h10,
      TGT_HOLDING_WIPE = 5'h11,
      TGT_SEARCH_INIT = 5'h12,
      TGT_RESERVED = 5'h1F
   } target_e;
   // Which connection memory a command acts on
   typedef enum logic [1:0] {
      BANK_EVEN = 2'h0,
      BANK_ODD = 2'h1,
      BANK_ALL = 2'h2,
      BANK_LOCAL = 2'h3
   } bank_e;
   // Gray coded along idle -> run -> done
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN = 2'b01,
      ST_DONE = 2'b11
   } op_state_e;
endpackage : indirect_access_pkg
`default_nettype wire

// >>> core/indirect_access_mode_decoder.sv
// Notes on behaviour
// - Selector: upper nibble space, lower nibble stream
// - Slot index byte indexes selected memory
// - Selector zero maps data onto control registers
// - Codes 1 and 2 select local data memories
// - Codes 4 and 5 select local connection fields
// - Code 70 wipes local holding registers
// - Code B0/B1/B2 select search memory fields
// - E0/E1/E3 make a link at next free
// - E4/E5/E7 break a link
// - E8/E9/EB clear slot named by index
// - EC/ED/EF read slot into data port
// - F0/F1/F3 search, result into data port
// - F8/F9/FB wipe whole connection memory
// - FC wipes only search holding registers
// - FF initialises all search memories
// - Control registers reset to zero
// - Main clock select field layout
// - Network reference select field layout
// - Selector at address 2, write only
// - Busy bit high during search memory access
`include "indirect_access_defines.svh"
`default_nettype none
module indirect_access_mode_decoder #(
   parameter int CR_DEPTH = 64
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic [1:0] i_addr,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] i_wdata,
   input wire logic [7:0] i_mem_rdata,
   input wire logic [7:0] i_search_result,
   output logic [7:0] o_rdata,
   output logic o_mem_wr,
   output logic o_mem_rd,
   output indirect_access_pkg::target_e o_target,
   output logic [3:0] o_stream,
   output logic [7:0] o_slot,
   output logic [7:0] o_mem_wdata,
   output indirect_access_pkg::bank_e o_bank,
   output logic o_cmd_start,
   output logic o_busy,
   output logic o_local_hold_wipe,
   output logic [7:0] o_main_clock_select,
   output logic [7:0] o_network_reference_clock_clock_select
);
   import indirect_access_pkg::*;

   // Refused at elaboration: the map needs offsets up to 0x32
   if (CR_DEPTH < 51 || CR_DEPTH > 256) begin : g_depth_check
      $error("CR_DEPTH must hold offsets up to 0x32");
   end

   // ==========================================
   // State
   typedef struct packed {
      logic [7:0] selector_reg;
      logic [7:0] slot_reg;
      logic [7:0] data_reg;
      logic [7:0] rdata_reg;
      logic mem_wr_reg;
      logic mem_rd_reg;
      logic cmd_start_reg;
      logic local_wipe_reg;
      logic read_pending_reg;
      op_state_e op_reg;
      logic [3:0] op_cnt_reg;
      target_e target_reg;
      bank_e bank_reg;
      logic busy_reg;
      logic [CR_DEPTH*8-1:0] cr_reg;
   } state_s;

   state_s st_reg;
   state_s st_next;
   target_e tgt;
   bank_e bank;
   target_e tgt_nx;
   bank_e bank_nx;
   logic [7:0] sel_nx;
   logic [7:0] cr_rd;
   logic cr_valid;
   logic search_cmd;

   // ==========================================
   // Selector decode
   function automatic bank_e bank_of(input logic [1:0] b);
      unique case (b)
         2'b00: bank_of = BANK_EVEN;
         2'b01: bank_of = BANK_ODD;
         2'b11: bank_of = BANK_LOCAL;
         default: bank_of = BANK_ALL;
      endcase
   endfunction : bank_of

   // Decoded from the next selector so target and bank leave flip-flops
   assign sel_nx = (i_wr && i_addr == `DIR_SELECTOR) ? i_wdata : st_reg.selector_reg;

   always_comb begin
      logic [3:0] sp;
      logic [3:0] lo;
      sp = sel_nx[`SEL_SPACE_MSB:`SEL_SPACE_LSB];
      lo = sel_nx[`SEL_LOW_MSB:`SEL_LOW_LSB];
      tgt_nx = TGT_RESERVED; // Undefined codes do nothing
      bank_nx = bank_of(lo[1:0]);
      unique case (sp)
         4'h0: if (lo == 4'h0) tgt_nx = TGT_CONTROL;
         4'h1: tgt_nx = TGT_LOCAL_DATA_ONE;
         4'h2: tgt_nx = TGT_LOCAL_DATA_TWO;
         4'h4: tgt_nx = TGT_LOCAL_CONN_SLOT;
         4'h5: tgt_nx = TGT_LOCAL_CONN_STREAM;
         4'h7: if (lo == 4'h0) tgt_nx = TGT_LOCAL_HOLD_WIPE;
         4'h9: if (lo == 4'h0) tgt_nx = TGT_SEARCH_DATA_ONE;
         4'hA: if (lo == 4'h0) tgt_nx = TGT_SEARCH_DATA_TWO;
         4'hB: begin
            if (lo == 4'h0) tgt_nx = TGT_SEARCH_SLOT;
            else if (lo == 4'h1) tgt_nx = TGT_SEARCH_STREAM;
            else if (lo == 4'h2) tgt_nx = TGT_SEARCH_TAG;
         end
         4'hE: begin
            if (lo[1:0] != 2'b10) begin
               unique case (lo[3:2])
                  2'b00: tgt_nx = TGT_MAKE_LINK;
                  2'b01: tgt_nx = TGT_BREAK_LINK;
                  2'b10: tgt_nx = TGT_CLEAR_SLOT;
                  2'b11: tgt_nx = TGT_READ_SLOT;
               endcase
            end
         end
         4'hF: begin
            if (lo == 4'hF) begin
               tgt_nx = TGT_SEARCH_INIT;
               bank_nx = BANK_ALL;
            end else if (lo == 4'hC) begin
               tgt_nx = TGT_HOLDING_WIPE;
               bank_nx = BANK_ALL;
            end else if (lo[1:0] != 2'b10 && lo[2] == 1'b0) begin
               tgt_nx = lo[3] ? TGT_WIPE : TGT_SEARCH;
            end
         end
         default: tgt_nx = TGT_RESERVED;
      endcase
   end

   // Registered copy always matches the decode of the held selector
   assign tgt = st_reg.target_reg;
   assign bank = st_reg.bank_reg;

   // Commands that run as a timed search-memory operation
   assign search_cmd = (tgt == TGT_MAKE_LINK) || (tgt == TGT_BREAK_LINK) ||
      (tgt == TGT_CLEAR_SLOT) || (tgt == TGT_READ_SLOT) || (tgt == TGT_SEARCH) ||
      (tgt == TGT_WIPE) || (tgt == TGT_HOLDING_WIPE) || (tgt == TGT_SEARCH_INIT);

   // ==========================================
   // Control register space
   always_comb begin
      cr_valid = 1'b0;
      unique case (st_reg.slot_reg)
         `CR_MAIN_CLOCK_SELECT, `CR_NETWORK_REFERENCE_CLOCK_CLOCK_SELECT, `CR_PROG_CLOCK_OUTPUTS,
         `CR_CLOCK_RESOURCE_SELECT, `CR_FALLBACK_CLOCK_SELECT, `CR_LOCAL_CLOCKS_UPPER,
         `CR_LOCAL_CLOCKS_LOWER, `CR_MAIN_CLOCK_DIVIDER, `CR_NETWORK_REFERENCE_CLOCK_CLOCK_DIVIDER,
         `CR_RESOURCE_CLOCK_DIVIDER, `CR_LOCAL_STREAM_CONTROL, `CR_CONNECTION_DELAY_TYPE,
         `CR_BACKPLANE_LOW, `CR_BACKPLANE_HIGH, `CR_GENERAL_PURPOSE_IO,
         `CR_FRAME_A_START_LOW, `CR_FRAME_A_HIGH, `CR_FRAME_B_START_LOW,
         `CR_FRAME_B_HIGH, `CR_FRAME_B_OUT_LOW, `CR_FRAME_B_OUT_HIGH,
         `CR_CLOCK_ERROR_IND, `CR_CLOCK_ERROR_STAT, `CR_SYSTEM_ERROR_FLAGS,
         `CR_CLOCK_WATCHDOG_MASK, `CR_DIAG_ONE, `CR_DIAG_TWO, `CR_DIAG_THREE:
            cr_valid = 1'b1;
         default: cr_valid = 1'b0;
      endcase
      cr_rd = cr_valid ? st_reg.cr_reg[st_reg.slot_reg*8 +: 8] : 8'h00;
   end

   // ==========================================
   // Next state
   always_comb begin
      logic ro;
      ro = (st_reg.slot_reg == `CR_CLOCK_ERROR_IND) ||
         (st_reg.slot_reg == `CR_CLOCK_ERROR_STAT) ||
         (st_reg.slot_reg == `CR_SYSTEM_ERROR_FLAGS);
      st_next = st_reg;
      st_next.mem_wr_reg = 1'b0;
      st_next.mem_rd_reg = 1'b0;
      st_next.cmd_start_reg = 1'b0;
      st_next.local_wipe_reg = 1'b0;
      // Search memory sequencer; busy while not idle
      unique case (st_reg.op_reg)
         ST_IDLE: ;
         ST_RUN: begin
            if (st_reg.op_cnt_reg == 4'h1) begin
               st_next.op_reg = ST_DONE;
            end
            st_next.op_cnt_reg = st_reg.op_cnt_reg - 4'h1;
         end
         ST_DONE: begin
            if (tgt == TGT_READ_SLOT || tgt == TGT_SEARCH) begin
               st_next.data_reg = i_search_result;
            end
            st_next.op_reg = ST_IDLE;
         end
         default: st_next.op_reg = ST_IDLE;
      endcase
      // Memory read data is captured in the same cycle as the strobe
      if (st_reg.read_pending_reg) begin
         st_next.data_reg = i_mem_rdata;
         st_next.read_pending_reg = 1'b0;
      end
      if (i_wr) begin
         unique case (i_addr)
            `DIR_MASTER: begin
               if (i_wdata[`MCR_SOFT_RESET_BIT]) begin
                  st_next.cr_reg = '0;
               end
            end
            `DIR_SLOT_INDEX: st_next.slot_reg = i_wdata;
            `DIR_SELECTOR: begin
               st_next.selector_reg = i_wdata;
            end
            `DIR_DATA: begin
               st_next.data_reg = i_wdata;
               if (tgt == TGT_CONTROL) begin
                  if (cr_valid && !ro) begin
                     st_next.cr_reg[st_reg.slot_reg*8 +: 8] = i_wdata;
                  end
               end else if (tgt != TGT_RESERVED && tgt != TGT_LOCAL_HOLD_WIPE &&
                  !search_cmd) begin
                  st_next.mem_wr_reg = 1'b1;
               end
            end
         endcase
      end
      // Commands fire when the data register is written and the unit is idle; code 70 fires on the selector write
      if (i_wr && i_addr == `DIR_SELECTOR) begin
         if (i_wdata == 8'h70) begin
            st_next.local_wipe_reg = 1'b1;
         end
      end
      if (st_reg.op_reg == ST_IDLE && search_cmd && st_reg.cmd_start_reg == 1'b0 &&
         i_wr && i_addr == `DIR_DATA) begin
         st_next.cmd_start_reg = 1'b1;
         st_next.op_reg = ST_RUN;
         st_next.op_cnt_reg = `SEARCH_OP_CYCLES;
      end
      if (i_rd && i_addr == `DIR_DATA) begin
         if (tgt != TGT_CONTROL && tgt != TGT_RESERVED && !search_cmd) begin
            st_next.mem_rd_reg = 1'b1;
            st_next.read_pending_reg = 1'b1;
         end
      end
      // Read mux: selector and slot index are write only
      unique case (i_addr)
         `DIR_MASTER: st_next.rdata_reg = {7'h00, (st_reg.op_reg != ST_IDLE)};
         `DIR_DATA: st_next.rdata_reg = (tgt == TGT_CONTROL) ? cr_rd : st_reg.data_reg;
         default: st_next.rdata_reg = 8'h00;
      endcase
      st_next.target_reg = tgt_nx;
      st_next.bank_reg = bank_nx;
      st_next.busy_reg = (st_next.op_reg != ST_IDLE);
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ==========================================
   // Outputs, all straight from the state
   assign o_rdata = st_reg.rdata_reg;
   assign o_mem_wr = st_reg.mem_wr_reg;
   assign o_mem_rd = st_reg.mem_rd_reg;
   assign o_target = st_reg.target_reg;
   assign o_stream = st_reg.selector_reg[`SEL_LOW_MSB:`SEL_LOW_LSB];
   assign o_slot = st_reg.slot_reg;
   assign o_mem_wdata = st_reg.data_reg;
   assign o_bank = st_reg.bank_reg;
   assign o_cmd_start = st_reg.cmd_start_reg;
   assign o_busy = st_reg.busy_reg;
   assign o_local_hold_wipe = st_reg.local_wipe_reg;
   assign o_main_clock_select = st_reg.cr_reg[`CR_MAIN_CLOCK_SELECT*8 +: 8];
   assign o_network_reference_clock_clock_select = st_reg.cr_reg[`CR_NETWORK_REFERENCE_CLOCK_CLOCK_SELECT*8 +: 8];
endmodule : indirect_access_mode_decoder
`default_nettype wire

// >>> sim/indirect_access_mode_decoder_monitor.sv
`default_nettype none
// ==========================================
// Port checker
module indirect_access_monitor (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic [1:0] i_addr,
   input wire logic i_wr,
   input wire logic [7:0] i_wdata,
   input wire indirect_access_pkg::target_e o_target,
   input wire indirect_access_pkg::bank_e o_bank,
   input wire logic [3:0] o_stream,
   input wire logic [7:0] o_slot,
   input wire logic o_mem_wr,
   input wire logic [7:0] o_mem_wdata,
   input wire logic o_cmd_start,
   input wire logic o_busy,
   input wire logic o_local_hold_wipe,
   input wire logic [7:0] o_main_clock_select,
   input wire logic [7:0] o_network_reference_clock_clock_select
);
   timeunit 1ns;
   timeprecision 1ns;
   import indirect_access_pkg::*;
   wire logic sel_wr = i_wr && i_addr == 2'h2;
   wire logic dat_wr = i_wr && i_addr == 2'h3;
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rst_n);
   // ==========================================
   // Assertions
   wipe_pulse_a: assert property (sel_wr && i_wdata == 8'h70 |=> o_local_hold_wipe)
      else $error("hold wipe pulse missing");
   wipe_cause_a: assert property (o_local_hold_wipe |-> $past(sel_wr && i_wdata == 8'h70))
      else $error("hold wipe pulse without cause");
   stream_field_a: assert property (sel_wr |=> o_stream == $past(i_wdata[3:0]))
      else $error("stream nibble wrong");
   slot_index_a: assert property (i_wr && i_addr == 2'h1 |=> o_slot == $past(i_wdata))
      else $error("slot index wrong");
   control_map_a: assert property (sel_wr && i_wdata == 8'h00 |=> o_target == TGT_CONTROL)
      else $error("control space not selected");
   make_even_a: assert property (sel_wr && i_wdata == 8'hE0 |=>
      o_target == TGT_MAKE_LINK && o_bank == BANK_EVEN)
      else $error("make even decode wrong");
   mem_write_a: assert property (dat_wr && o_target == TGT_LOCAL_DATA_ONE |=>
      o_mem_wr && o_mem_wdata == $past(i_wdata))
      else $error("local memory write missing");
   busy_length_a: assert property ($rose(o_busy) |-> o_busy [*5] ##1 !o_busy)
      else $error("busy length wrong");
   start_busy_a: assert property (o_cmd_start |-> o_busy)
      else $error("command start without busy");
   main_write_a: assert property (dat_wr && o_target == TGT_CONTROL && o_slot == 8'h00 |=>
      o_main_clock_select == $past(i_wdata))
      else $error("main clock select not written");
   network_reference_clock_write_a: assert property (dat_wr && o_target == TGT_CONTROL && o_slot == 8'h01 |=>
      o_network_reference_clock_clock_select == $past(i_wdata))
      else $error("network_reference_clock select not written");
   cover property (o_local_hold_wipe);
   cover property ($rose(o_busy));
   cover property (dat_wr && o_target == TGT_CONTROL);
endmodule : indirect_access_monitor
bind indirect_access_mode_decoder indirect_access_monitor mon (.i_clk_sys, .i_rst_n, .i_addr,
   .i_wr, .i_wdata, .o_target, .o_bank, .o_stream, .o_slot, .o_mem_wr, .o_mem_wdata,
   .o_cmd_start, .o_busy, .o_local_hold_wipe, .o_main_clock_select, .o_network_reference_clock_clock_select);
`default_nettype wire

// >>> sim/indirect_access_far_model.sv
`default_nettype none
// ==========================================
// Memory and search engine on the far side
module indirect_access_far_model #(
   parameter logic [7:0] FIND_RESULT = 8'hA5
) (
   input wire logic i_clk_sys,
   input wire logic i_mem_wr,
   input wire logic i_mem_rd,
   input wire logic i_busy,
   input wire logic [3:0] i_stream,
   input wire logic [7:0] i_slot,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_mem_rdata,
   output logic [7:0] o_search_result
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [4096];
   logic [7:0] last_reg = 8'h00;
   logic rd_d_reg = 1'b0;
   always_ff @(posedge i_clk_sys) begin
      rd_d_reg <= i_mem_rd;
      if (i_mem_wr) begin
         mem[{i_stream, i_slot}] <= i_wdata;
      end
      if (rd_d_reg) begin
         last_reg <= mem[{i_stream, i_slot}];
      end
   end
   // Stale data inverted, so a late sample never matches by luck
   assign o_mem_rdata = (i_mem_rd || rd_d_reg) ? mem[{i_stream, i_slot}] : ~last_reg;
   assign o_search_result = i_busy ? FIND_RESULT : ~FIND_RESULT;
endmodule : indirect_access_far_model
`default_nettype wire

// >>> sim/indirect_access_mode_decoder_tb_top.sv
`default_nettype none
module indirect_access_mode_decoder_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import indirect_access_pkg::*;
   logic i_clk_sys = 1'b0;
   logic i_rst_n = 1'b0;
   logic [1:0] i_addr = 2'h0;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [7:0] i_wdata = 8'h00;
   logic [7:0] i_mem_rdata, i_search_result, o_rdata, o_mem_wdata, o_slot, v;
   logic [7:0] o_main_clock_select, o_network_reference_clock_clock_select;
   logic o_mem_wr, o_mem_rd, o_cmd_start, o_busy, o_local_hold_wipe;
   logic [3:0] o_stream;
   target_e o_target;
   bank_e o_bank;
   int n_errors = 0;
   int n_compared = 0;
   int cycles = 0;
   // Offset, value written, value read back
   logic [23:0] cr_rows [] = '{24'h005A5A, 24'h01C3C3, 24'h0E8181, 24'h32FFFF,
      24'h0A7700, 24'h281100, 24'h33AA00, 24'h2B3C3C};
   // Selector code, target code
   logic [15:0] dec_rows [] = '{16'h0000, 16'h1301, 16'h2F02, 16'h4503, 16'h5A04, 16'h7005,
      16'h9006, 16'hA007, 16'hB008, 16'hB109, 16'hB20A, 16'hE00B, 16'hE10B, 16'hE30B,
      16'hE40C, 16'hE50C, 16'hE70C, 16'hE80D, 16'hE90D, 16'hEB0D, 16'hEC0E, 16'hED0E,
      16'hEF0E, 16'hF00F, 16'hF10F, 16'hF30F, 16'hF810, 16'hF910, 16'hFB10, 16'hFC11,
      16'hFF12, 16'h2702};
   // Commands whose result comes back through the data port
   logic [7:0] cmd_codes [] = '{8'hF0, 8'hEC};
   indirect_access_mode_decoder DUT (.i_clk_sys, .i_rst_n, .i_addr, .i_wr, .i_rd, .i_wdata,
      .i_mem_rdata, .i_search_result, .o_rdata, .o_mem_wr, .o_mem_rd, .o_target, .o_stream,
      .o_slot, .o_mem_wdata, .o_bank, .o_cmd_start, .o_busy, .o_local_hold_wipe,
      .o_main_clock_select, .o_network_reference_clock_clock_select);
   indirect_access_far_model far (.i_clk_sys, .i_mem_wr(o_mem_wr), .i_mem_rd(o_mem_rd),
      .i_busy(o_busy), .i_stream(o_stream), .i_slot(o_slot), .i_wdata(o_mem_wdata),
      .o_mem_rdata(i_mem_rdata), .o_search_result(i_search_result));
   // ==========================================
   // Clock and hang guard
   initial begin
      forever #50 i_clk_sys = ~i_clk_sys;
   end
   always @(posedge i_clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_errors++;
         $display("mismatch at %0t: timeout", $time);
         tally_and_finish();
      end
   end
   // ==========================================
   // Tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Gap cycle after each access so strobes never toggle twice in one step
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
      @(posedge i_clk_sys);
   endtask : wr
   task automatic rd(input logic [1:0] a, output logic [7:0] d);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      #1 d = o_rdata;
      @(posedge i_clk_sys);
   endtask : rd
   task automatic tally_and_finish();
      if (n_errors == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : tally_and_finish
   // ==========================================
   // Main sequence
   initial begin
      int k;
      k = 0;
      repeat (3) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      #1;
      chk(o_network_reference_clock_clock_select, 8'h00);
      chk({3'h0, o_target}, {3'h0, TGT_CONTROL});
      @(posedge i_clk_sys);
      wr(2'h2, 8'h00);
      foreach (cr_rows[i]) begin
         wr(2'h1, cr_rows[i][23:16]);
         rd(2'h3, v);
         chk(v, 8'h00);
         wr(2'h3, cr_rows[i][15:8]);
         rd(2'h3, v);
         chk(v, cr_rows[i][7:0]);
      end
      chk(o_main_clock_select, 8'h5A);
      chk(o_network_reference_clock_clock_select, 8'hC3);
      foreach (dec_rows[i]) begin
         wr(2'h2, dec_rows[i][15:8]);
         chk({3'h0, o_target}, {3'h0, dec_rows[i][4:0]});
         if (dec_rows[i][15:13] == 3'b111 &&
            (!dec_rows[i][12] || dec_rows[i][11:10] != 2'b11)) begin
            chk({6'h0, o_bank}, {6'h0, dec_rows[i][9:8]});
         end
      end
      wr(2'h2, 8'h13);
      for (int s = 0; s < 2; s++) begin
         wr(2'h1, 8'h22 + 8'(s));
         wr(2'h3, 8'h6B + 8'(s));
      end
      wr(2'h1, 8'h22);
      rd(2'h3, v);
      rd(2'h3, v);
      chk(v, 8'h6B);
      foreach (cmd_codes[c]) begin
         wr(2'h2, cmd_codes[c]);
         wr(2'h3, 8'h00);
         rd(2'h0, v);
         chk({7'h0, v[0]}, 8'h01);
         k = 0;
         while (o_busy === 1'b1 && k < 20) begin
            @(posedge i_clk_sys);
            #1 k++;
         end
         chk({7'h0, o_busy}, 8'h00);
         @(posedge i_clk_sys);
         rd(2'h3, v);
         chk(v, 8'hA5);
      end
      rd(2'h2, v);
      chk(v, 8'h00);
      wr(2'h0, 8'h80);
      chk(o_main_clock_select, 8'h00);
      // Mid-run reset: selector and slot index must fall back to zero
      i_rst_n <= 1'b0;
      @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      #1 chk({3'h0, o_target}, {3'h0, TGT_CONTROL});
      chk(o_slot, 8'h00);
      tally_and_finish();
   end
endmodule : indirect_access_mode_decoder_tb_top
`default_nettype wire
